// [verilog/mfc_config.sv]
// serial register port, modulator and framing registers, decoded config
// assumes serial pins from the host and base frequency word from this clock
`timescale 1ns/100ps

module mfc_config (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // serial configuration port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  // base frequency word, units of crystal over 2^16
  input wire logic [23:0] base_frequency,
  // decoded configuration
  output mfc_pkg::mfc_tx_cfg_t tx_cfg,
  output logic [19:0] channel_offset,
  output logic [26:0] synth_word
);

  // ==========================================================
  // pin synchronisers
  logic sclk_lvl, cs_n_lvl, si_lvl;

  mfc_pin_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .clock(clock),
    .reset_n(reset_n),
    .pin(spi_sclk),
    .level(sclk_lvl)
  );

  mfc_pin_sync #(.RESET_VAL(1'b1)) u_sync_cs (
    .clock(clock),
    .reset_n(reset_n),
    .pin(spi_cs_n),
    .level(cs_n_lvl)
  );

  mfc_pin_sync #(.RESET_VAL(1'b0)) u_sync_si (
    .clock(clock),
    .reset_n(reset_n),
    .pin(spi_si),
    .level(si_lvl)
  );

  // ==========================================================
  // register state
  logic [7:0] mdm2_reg, mdm2_next;
  logic [7:0] mdm1_reg, mdm1_next;
  logic [7:0] mdm0_reg, mdm0_next;
  logic [7:0] channel_number_reg, channel_number_next;
  logic [1:0] len_cfg_reg, len_cfg_next;

  // serial engine state
  mfc_pkg::mfc_state_t st_reg, st_next;
  logic sclk_d_reg;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] sh_in_reg, sh_in_next;
  logic [5:0] addr_reg, addr_next;
  logic rd_reg, rd_next;
  logic burst_reg, burst_next;
  logic [7:0] so_sh_reg, so_sh_next;
  logic so_oe_reg, so_oe_next;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] byte_in;
  logic rise, fall;

  // decoded outputs
  mfc_pkg::mfc_tx_cfg_t cfg_reg, cfg_next;
  logic [11:0] spacing;
  logic [19:0] offset_reg, offset_next;
  logic [26:0] synth_reg, synth_next;

  assign rise = sclk_lvl & ~sclk_d_reg;
  assign fall = ~sclk_lvl & sclk_d_reg;
  assign byte_in = {sh_in_reg[6:0], si_lvl};

  // ==========================================================
  // read mux; unmapped offsets read zero
  always_comb begin
    if (addr_reg == mfc_pkg::ADDR_MDM2) begin
      rd_data = mdm2_reg & mfc_pkg::WMASK_MDM2;
    end else if (addr_reg == mfc_pkg::ADDR_MDM1) begin
      rd_data = mdm1_reg & mfc_pkg::WMASK_MDM1;
    end else if (addr_reg == mfc_pkg::ADDR_MDM0) begin
      rd_data = mdm0_reg;
    end else if (addr_reg == mfc_pkg::ADDR_CHANNEL_NUMBER) begin
      rd_data = channel_number_reg;
    end else if (addr_reg == mfc_pkg::ADDR_PKT_CTRL) begin
      rd_data = {6'h00, len_cfg_reg};
    end else begin
      rd_data = 8'h00;
    end
  end

  // ==========================================================
  // serial engine: header byte, then one or a burst of data bytes
  always_comb begin
    st_next = st_reg;
    bit_cnt_next = bit_cnt_reg;
    sh_in_next = sh_in_reg;
    addr_next = addr_reg;
    rd_next = rd_reg;
    burst_next = burst_reg;
    so_sh_next = so_sh_reg;
    so_oe_next = 1'b1;
    wr_en = 1'b0;
    wr_data = byte_in;
    if (cs_n_lvl) begin
      // deselect aborts any partial byte
      st_next = mfc_pkg::MFC_ST_IDLE;
      bit_cnt_next = 3'h0;
      so_sh_next = 8'h00;
      so_oe_next = 1'b0;
    end else begin
      if (st_reg == mfc_pkg::MFC_ST_IDLE) begin
        st_next = mfc_pkg::MFC_ST_HDR;
      end
      if (rise) begin
        sh_in_next = byte_in;
        bit_cnt_next = bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          if (st_reg != mfc_pkg::MFC_ST_DATA) begin
            rd_next = byte_in[mfc_pkg::HDR_RD_BIT];
            burst_next = byte_in[mfc_pkg::HDR_BURST_BIT];
            addr_next = byte_in[5:0];
            st_next = mfc_pkg::MFC_ST_DATA;
          end else begin
            wr_en = ~rd_reg;
            if (burst_reg) begin
              addr_next = addr_reg + 6'h01;
            end else begin
              st_next = mfc_pkg::MFC_ST_HDR;
            end
          end
        end
      end else if (fall) begin
        // load on the fall after a byte so the first bit is set up early
        if (bit_cnt_reg == 3'h0 && st_reg == mfc_pkg::MFC_ST_DATA && rd_reg) begin
          so_sh_next = rd_data;
        end else begin
          so_sh_next = {so_sh_reg[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= mfc_pkg::MFC_ST_IDLE;
      sclk_d_reg <= 1'b0;
      bit_cnt_reg <= 3'h0;
      sh_in_reg <= 8'h00;
      addr_reg <= 6'h00;
      rd_reg <= 1'b0;
      burst_reg <= 1'b0;
      so_sh_reg <= 8'h00;
      so_oe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sclk_d_reg <= sclk_lvl;
      bit_cnt_reg <= bit_cnt_next;
      sh_in_reg <= sh_in_next;
      addr_reg <= addr_next;
      rd_reg <= rd_next;
      burst_reg <= burst_next;
      so_sh_reg <= so_sh_next;
      so_oe_reg <= so_oe_next;
    end
  end

  // ==========================================================
  // register writes
  always_comb begin
    mdm2_next = mdm2_reg;
    mdm1_next = mdm1_reg;
    mdm0_next = mdm0_reg;
    channel_number_next = channel_number_reg;
    len_cfg_next = len_cfg_reg;
    if (wr_en) begin
      if (addr_reg == mfc_pkg::ADDR_MDM2) begin
        mdm2_next = wr_data & mfc_pkg::WMASK_MDM2;
      end else if (addr_reg == mfc_pkg::ADDR_MDM1) begin
        mdm1_next = wr_data & mfc_pkg::WMASK_MDM1;
      end else if (addr_reg == mfc_pkg::ADDR_MDM0) begin
        mdm0_next = wr_data;
      end else if (addr_reg == mfc_pkg::ADDR_CHANNEL_NUMBER) begin
        channel_number_next = wr_data;
      end else if (addr_reg == mfc_pkg::ADDR_PKT_CTRL) begin
        len_cfg_next = wr_data[1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mdm2_reg <= mfc_pkg::RST_MDM2;
      mdm1_reg <= mfc_pkg::RST_MDM1;
      mdm0_reg <= mfc_pkg::RST_MDM0;
      channel_number_reg <= mfc_pkg::RST_CHANNEL_NUMBER;
      len_cfg_reg <= mfc_pkg::RST_LEN_CFG;
    end else begin
      mdm2_reg <= mdm2_next;
      mdm1_reg <= mdm1_next;
      mdm0_reg <= mdm0_next;
      channel_number_reg <= channel_number_next;
      len_cfg_reg <= len_cfg_next;
    end
  end

  // ==========================================================
  // decode of framing fields and frequency arithmetic
  always_comb begin
    cfg_next.modulation = mfc_pkg::mfc_mod_t'(mdm2_reg[mfc_pkg::MOD_LSB +: 3]);
    cfg_next.mod_defined = (mdm2_reg[mfc_pkg::MOD_LSB +: 3] == 3'h0)
      || (mdm2_reg[mfc_pkg::MOD_LSB +: 3] == 3'h1)
      || (mdm2_reg[mfc_pkg::MOD_LSB +: 3] == 3'h3)
      || (mdm2_reg[mfc_pkg::MOD_LSB +: 3] == 3'h7);
    cfg_next.manchester = mdm2_reg[mfc_pkg::MAN_BIT]
      && (len_cfg_reg == mfc_pkg::LEN_FIXED);
    cfg_next.preamble_on = mdm2_reg[mfc_pkg::SYNC_LSB +: 2] != 2'h0;
    cfg_next.sync_on = mdm2_reg[mfc_pkg::SYNC_LSB +: 2] != 2'h0;
    cfg_next.sync_repeat = mdm2_reg[mfc_pkg::SYNC_LSB +: 2] == 2'h3;
    cfg_next.fec = mdm1_reg[mfc_pkg::FEC_BIT];
    cfg_next.preamble_bytes = mfc_pkg::PREAMBLE_LUT[mdm1_reg[mfc_pkg::PRE_LSB +: 3]];
    // spacing with hidden one, scaled by exponent
    spacing = 12'({1'b1, mdm0_reg}) << mdm1_reg[mfc_pkg::EXP_LSB +: 2];
    // offset and synth word in crystal over 2^18
    offset_next = 20'(spacing) * 20'(channel_number_reg);
    synth_next = 27'({base_frequency, 2'b00}) + 27'(offset_next);
  end

  // one register stage keeps the multiplier off the output paths
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= '0;
      offset_reg <= 20'h00000;
      synth_reg <= 27'h0000000;
    end else begin
      cfg_reg <= cfg_next;
      offset_reg <= offset_next;
      synth_reg <= synth_next;
    end
  end

  assign tx_cfg = cfg_reg;
  assign channel_offset = offset_reg;
  assign synth_word = synth_reg;
  assign spi_so = so_sh_reg[7];
  assign spi_so_oe = so_oe_reg;

  // ==========================================================
  // assertions
  a_mod_undefined: assert property (@(posedge clock) disable iff (!reset_n)
    (mdm2_reg[6:4] == 3'h2) |=> !tx_cfg.mod_defined)
    else $error("undefined modulation code reported defined");

  a_mod_msk: assert property (@(posedge clock) disable iff (!reset_n)
    (mdm2_reg[6:4] == 3'h7) |=> tx_cfg.modulation == mfc_pkg::MFC_MOD_MSK
      && tx_cfg.mod_defined)
    else $error("msk code not decoded");

  a_manchester_fixed: assert property (@(posedge clock) disable iff (!reset_n)
    tx_cfg.manchester |-> $past(mdm2_reg[3]) && ($past(len_cfg_reg) == 2'h0))
    else $error("manchester outside fixed length mode");

  a_sync_off: assert property (@(posedge clock) disable iff (!reset_n)
    (mdm2_reg[1:0] == 2'h0) |=> !tx_cfg.sync_on && !tx_cfg.preamble_on)
    else $error("sync or preamble on for disabled mode");

  a_sync_topbit: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 tx_cfg.sync_repeat == ($past(mdm2_reg[1:0]) == 2'h3))
    else $error("sync repeat depends on top selector bit");

  a_fec_follow: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(mdm1_reg[7]) |=> tx_cfg.fec)
    else $error("error coding not enabled");

  a_preamble_max: assert property (@(posedge clock) disable iff (!reset_n)
    (mdm1_reg[6:4] == 3'h7) |=> tx_cfg.preamble_bytes == 5'h18)
    else $error("preamble count for code seven wrong");

  a_spacing_scale: assert property (@(posedge clock) disable iff (!reset_n)
    (mdm0_reg == 8'h00 && mdm1_reg[1:0] == 2'h0 && channel_number_reg == 8'h01)
      |=> channel_offset == 20'h00100)
    else $error("spacing scale wrong");

  a_synth_base: assert property (@(posedge clock) disable iff (!reset_n)
    (channel_number_reg == 8'h00) |=> synth_word == {1'b0, $past(base_frequency), 2'b00})
    else $error("synth word differs from base at channel zero");

  a_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
    !mdm2_reg[7] && (mdm1_reg[3:2] == 2'h0))
    else $error("reserved bit set");

endmodule // mfc_config

// [verilog/mfc_pkg.sv]
// constants, types and lookup tables for the modulator and framing config
// assumes one 200 MHz clock domain and a byte-wide serial register port
//
// What this block does
// - modulation selector picks 2-FSK, GFSK, OOK, MSK
// - Manchester bit encodes data, fixed length only
// - sync selector: none, 16-bit, or repeated sync
// - sync selector codes one and two decode alike
// - error coding bit enables payload coding, interleaving
// - preamble code maps to 2..24 bytes
// - two-bit exponent scales channel spacing
// - spacing is (256 plus mantissa) shifted by exponent
// - synth word is base plus spacing times channel
// - length config zero means fixed packet length
// - eight-bit unsigned channel number register
package mfc_pkg;

  // ==========================================================
  // serial port header layout
  localparam int HDR_RD_BIT = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam int ADDR_W = 6;

  // ==========================================================
  // register offsets
  localparam logic [5:0] ADDR_PKT_CTRL = 6'h08;
  localparam logic [5:0] ADDR_CHANNEL_NUMBER = 6'h0a;
  localparam logic [5:0] ADDR_MDM2 = 6'h12;
  localparam logic [5:0] ADDR_MDM1 = 6'h13;
  localparam logic [5:0] ADDR_MDM0 = 6'h14;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_MDM2 = 8'h12;
  localparam logic [7:0] RST_MDM1 = 8'h22;
  localparam logic [7:0] RST_MDM0 = 8'hf8;
  localparam logic [7:0] RST_CHANNEL_NUMBER = 8'h00;
  localparam logic [1:0] RST_LEN_CFG = 2'h1;

  // ==========================================================
  // writable bits; everything else is reserved and held at zero
  localparam logic [7:0] WMASK_MDM2 = 8'h7f;
  localparam logic [7:0] WMASK_MDM1 = 8'hf3;

  // ==========================================================
  // field positions
  localparam int MOD_LSB = 4;
  localparam int MAN_BIT = 3;
  localparam int SYNC_LSB = 0;
  localparam int FEC_BIT = 7;
  localparam int PRE_LSB = 4;
  localparam int EXP_LSB = 0;
  localparam logic [1:0] LEN_FIXED = 2'h0;

  // ==========================================================
  // preamble byte counts indexed by code
  localparam logic [7:0][4:0] PREAMBLE_LUT = {
    5'h18, 5'h10, 5'h0c, 5'h08, 5'h06, 5'h04, 5'h03, 5'h02};

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    MFC_MOD_FSK2 = 3'h0,
    MFC_MOD_GFSK = 3'h1,
    MFC_MOD_OOK = 3'h3,
    MFC_MOD_MSK = 3'h7
  } mfc_mod_t;

  typedef enum logic [1:0] {
    MFC_ST_IDLE = 2'h0,
    MFC_ST_HDR = 2'h1,
    MFC_ST_DATA = 2'h3
  } mfc_state_t;

  typedef struct packed {
    mfc_mod_t modulation;
    logic mod_defined;
    logic manchester;
    logic preamble_on;
    logic sync_on;
    logic sync_repeat;
    logic fec;
    logic [4:0] preamble_bytes;
  } mfc_tx_cfg_t;

endpackage

// [verilog/mfc_pin_sync.sv]
// three-stage synchroniser with agreement filter for one pin
// assumes an asynchronous pin and the block clock
`timescale 1ns/100ps

module mfc_pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // pin and clean level
  input wire logic pin,
  output logic level
);

  logic s1_reg, s2_reg, s3_reg, level_reg;
  logic level_next;

  // ==========================================================
  // filter: a change counts only once stages two and three agree
  always_comb begin
    level_next = level_reg;
    if (s2_reg == s3_reg) begin
      level_next = s3_reg;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      level_reg <= RESET_VAL;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule // mfc_pin_sync

// [dv/mfc_host_model.sv]
// host model driving the serial configuration port of the config block
// assumes the block samples the pins through its own synchronisers
`timescale 1ns/100ps

module mfc_host_model (
  // clock
  input wire logic clock,
  // serial port
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_si,
  input wire logic spi_so,
  input wire logic spi_so_oe
);
  // ==========================================
  // frame buffers, filled and read by the bench
  logic [7:0] tx_buf [4];
  logic [7:0] rx_buf [4];
  logic [7:0] status;

  // serial clock stands low outside frames
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end

  // one byte msb first; 8-clock phases leave margin over the synchroniser
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      spi_si <= tx[i];
      repeat (7) @(posedge clock);
      @(negedge clock);
      // an undriven output must not pass for data
      rx[i] = spi_so_oe ? spi_so : 1'bx;
      @(posedge clock);
      spi_sclk <= 1'b1;
      repeat (8) @(posedge clock);
      spi_sclk <= 1'b0;
    end
  endtask

  // header then n bytes; cut below 8 drops select inside the last byte
  task automatic frame(input logic [7:0] hdr, input int n, input int cut);
    @(posedge clock);
    spi_cs_n <= 1'b0;
    repeat (4) @(posedge clock);
    xfer(hdr, 8, status);
    for (int k = 0; k < n; k++)
      xfer(tx_buf[k], (k == n - 1) ? cut : 8, rx_buf[k]);
    repeat (8) @(posedge clock);
    spi_cs_n <= 1'b1;
    // released data line shows no stale value
    spi_si <= ~spi_si;
    repeat (8) @(posedge clock);
  endtask
endmodule // mfc_host_model

// [dv/testbench.sv]
// self-checking bench for the modulator and framing config block
// assumes the host model drives the serial port and the bench the base word
`timescale 1ns/100ps

module testbench;
  localparam int LIMIT = 40000;
  localparam logic [5:0] A2 = mfc_pkg::ADDR_MDM2;
  localparam logic [5:0] A1 = mfc_pkg::ADDR_MDM1;
  localparam logic [5:0] A0 = mfc_pkg::ADDR_MDM0;
  localparam logic [5:0] ACH = mfc_pkg::ADDR_CHANNEL_NUMBER;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [23:0] base_frequency = 24'h5a1234;
  logic spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_oe;
  mfc_pkg::mfc_tx_cfg_t tx_cfg;
  logic [19:0] channel_offset;
  logic [26:0] synth_word;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int exp_off;
  logic [7:0] rd;
  logic [4:0] pre_exp [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18};
  logic [7:0] sp_m [4] = '{8'h00, 8'h80, 8'hf8, 8'hff};
  logic [7:0] sp_ch [4] = '{8'h01, 8'h03, 8'h10, 8'hff};

  always #2.5 clock = ~clock;

  // ==========================================
  // design and host
  mfc_config mfc_config_i (.clock(clock), .reset_n(reset_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
    .base_frequency(base_frequency), .tx_cfg(tx_cfg), .channel_offset(channel_offset),
    .synth_word(synth_word));
  mfc_host_model mfc_host_model_i (.clock(clock), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe));

  // ==========================================
  // compares and verdict
  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_val(input string what, input logic [26:0] exp, input logic [26:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // single-byte accesses; outputs are looked at on the falling edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    mfc_host_model_i.tx_buf[0] = d;
    mfc_host_model_i.frame({2'b00, a}, 1, 8);
    @(negedge clock);
  endtask

  task automatic rd_reg(input logic [5:0] a);
    mfc_host_model_i.frame({2'b10, a}, 1, 8);
    rd = mfc_host_model_i.rx_buf[0];
    @(negedge clock);
  endtask

  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd_reg(A2);
    chk_reg("mdm2_reset", 8'h12, rd);
    rd_reg(A1);
    chk_reg("mdm1_reset", 8'h22, rd);
    rd_reg(A0);
    chk_reg("mdm0_reset", 8'hf8, rd);
    rd_reg(ACH);
    chk_reg("channel_number_reset", 8'h00, rd);
    chk_val("synth_reset", 27'({base_frequency, 2'b00}), synth_word);
    // every modulation and sync code, reserved bit set
    for (int c = 0; c < 8; c++) begin
      wr(A2, {1'b1, 3'(c), 1'b0, 3'(c)});
      chk_val("modulation", 27'(c), 27'(tx_cfg.modulation));
      chk_val("mod_defined", 27'(c inside {0, 1, 3, 7}), 27'(tx_cfg.mod_defined));
      chk_val("sync_on", 27'(c[1:0] != 2'b00), 27'(tx_cfg.sync_on));
      chk_val("preamble_on", 27'(c[1:0] != 2'b00), 27'(tx_cfg.preamble_on));
      chk_val("sync_repeat", 27'(c[1:0] == 2'b11), 27'(tx_cfg.sync_repeat));
      rd_reg(A2);
      chk_reg("mdm2_readback", {1'b0, 3'(c), 1'b0, 3'(c)}, rd);
    end
    // host sets manchester only after fixed length is selected
    wr(mfc_pkg::ADDR_PKT_CTRL, 8'hfc);
    rd_reg(mfc_pkg::ADDR_PKT_CTRL);
    chk_reg("pkt_ctrl_readback", 8'h00, rd);
    wr(A2, 8'h0a);
    chk_val("manchester_fixed", 27'h1, 27'(tx_cfg.manchester));
    // leaving fixed length must gate the coding off again
    wr(mfc_pkg::ADDR_PKT_CTRL, 8'h01);
    chk_val("manchester_variable", 27'h0, 27'(tx_cfg.manchester));
    wr(A2, 8'h02);
    chk_val("manchester_off", 27'h0, 27'(tx_cfg.manchester));
    // every preamble code, error coding toggled
    for (int c = 0; c < 8; c++) begin
      wr(A1, {c[0], 3'(c), 2'b11, 2'(c)});
      chk_val("fec", 27'(c[0]), 27'(tx_cfg.fec));
      chk_val("preamble_bytes", 27'(pre_exp[c]), 27'(tx_cfg.preamble_bytes));
      rd_reg(A1);
      chk_reg("mdm1_readback", {c[0], 3'(c), 2'b00, 2'(c)}, rd);
    end
    // spacing per exponent, burst write of exponent and mantissa
    for (int i = 0; i < 4; i++) begin
      mfc_host_model_i.tx_buf[0] = {1'b0, 3'h2, 2'b00, 2'(i)};
      mfc_host_model_i.tx_buf[1] = sp_m[i];
      mfc_host_model_i.frame({2'b01, A1}, 2, 8);
      wr(ACH, sp_ch[i]);
      exp_off = ((256 + int'(sp_m[i])) << i) * int'(sp_ch[i]);
      chk_val("channel_offset", 27'(exp_off), 27'(channel_offset));
      chk_val("synth_word", 27'({base_frequency, 2'b00}) + 27'(exp_off), synth_word);
      rd_reg(ACH);
      chk_reg("channel_number_readback", sp_ch[i], rd);
      rd_reg(A0);
      chk_reg("mdm0_readback", sp_m[i], rd);
    end
    @(posedge clock);
    base_frequency <= 24'hffffff;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk_val("synth_base", 27'({24'hffffff, 2'b00}) + 27'(exp_off), synth_word);
    // unmapped offset and a write cut short by deselect
    wr(6'h3f, 8'h5a);
    rd_reg(6'h3f);
    chk_reg("unmapped", 8'h00, rd);
    mfc_host_model_i.tx_buf[0] = 8'h00;
    mfc_host_model_i.frame({2'b00, A0}, 1, 5);
    rd_reg(A0);
    chk_reg("aborted_write", 8'hff, rd);
    summarize();
  end
endmodule // testbench
